// File: common/fan_speed_pkg.sv
package fan_speed_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
   localparam logic [7:0]  STATUS_OFFSET  = 8'h04;
   localparam logic [7:0]  HIGH_OFFSET    = 8'h08;
   localparam logic [7:0]  LOW_OFFSET     = 8'h0C;

   localparam int          STAT_RANGE_BIT  = 0;
   localparam int          STAT_PIN_BIT    = 1;
   localparam int          STAT_TOGGLE_BIT = 2;
   localparam int          STAT_READY_BIT  = 3;

   localparam int          CTRL_RANGE_EN_BIT  = 0;
   localparam int          CTRL_MODE_BIT      = 10;
   localparam int          CTRL_EDGES_LSB     = 11;
   localparam int          CTRL_TOGGLE_EN_BIT = 14;
   localparam int          CTRL_READY_EN_BIT  = 15;
   localparam int          CTRL_COUNT_LSB     = 16;

   localparam int          CNT_W       = 16;
   localparam logic [15:0] HIGH_RESET  = 16'hFFFF;
   localparam logic [15:0] LOW_RESET   = 16'h0000;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS  = 8000;
   localparam int REF_PERIOD_NS  = 10000;
   localparam int REF_DIV_CYCLES = (REF_PERIOD_NS * 1000) / CLK_PERIOD_PS;

   // Number of input edges that close one measurement interval.
   function automatic logic [3:0] edges_needed(input logic [1:0] sel);
      unique case (sel)
         2'h0: edges_needed = 4'h2;
         2'h1: edges_needed = 4'h3;
         2'h2: edges_needed = 4'h5;
         2'h3: edges_needed = 4'h9;
      endcase
   endfunction

endpackage

// File: src/fan_speed_monitor_status.sv
// Operation
// RQ1: In interval mode the ready flag (bit 3) sets each time a count is latched.
// RQ2: In edge-count mode the ready flag stays 0 and never sets.
// RQ3: Writing 1 clears the ready flag; with its enable set it raises the interrupt.
// RQ4: The toggle flag (bit 2) sets on every rising or falling input change.
// RQ5: Writing 1 clears the toggle flag; with its enable set it raises the interrupt.
// RQ6: Bit 1 reads the present level of the speed-sense input.
// RQ7: The range flag (bit 0) sets while the count is above high or below low limit.
// RQ8: Writing 1 clears the range flag; with its enable set it raises the interrupt.
// RQ9: Software wanting no range events programs the limits to their extremes.
// RQ10: Software reads the flags at start-up, as a stuck input never toggles.
// RQ11: The high trip is strictly greater than the high limit, which resets to all ones.
// RQ12: The low limit resets to zero, which disables the low trip.
// RQ13: In interval mode reference ticks are counted and latched after the set edges.
// RQ14: The interrupt is the OR of the enabled flags and drops when they are cleared.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module fan_speed_monitor_status
   import fan_speed_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              tach_in,
   output logic                   monitor_irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic              aw_held_q, w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              wr_fire;
   logic              range_irq_enable_q, toggle_irq_enable_q, ready_irq_enable_q;
   logic              mode_select_q;
   logic [1:0]        edge_select_q;
   logic [CNT_W-1:0]  upper_count_bound_q, lower_count_bound_q;
   logic              tach_q, primed_q, tach_change, tach_rise;
   logic [CNT_W-1:0]  edge_count_value;
   logic              count_latched, out_of_range;
   logic              range_violation_flag_q, toggle_flag_q, ready_flag_q;
   logic              clr_range, clr_toggle, clr_ready;
   logic [31:0]       status_word, ctrl_word;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, CTRL_OFFSET) || hit(a, STATUS_OFFSET)
               || hit(a, HIGH_OFFSET) || hit(a, LOW_OFFSET);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
   assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn || wr_fire) begin
         aw_held_q <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || wr_fire) begin
         w_held_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Control and limit registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         range_irq_enable_q  <= 1'b0;
         mode_select_q       <= 1'b0;
         edge_select_q       <= 2'h0;
         toggle_irq_enable_q <= 1'b0;
         ready_irq_enable_q  <= 1'b0;
      end else if (wr_fire && hit(awaddr_q, CTRL_OFFSET)) begin
         if (wstrb_q[0]) begin
            range_irq_enable_q <= wdata_q[CTRL_RANGE_EN_BIT];
         end
         if (wstrb_q[1]) begin
            mode_select_q       <= wdata_q[CTRL_MODE_BIT];
            edge_select_q       <= wdata_q[CTRL_EDGES_LSB +: 2];
            toggle_irq_enable_q <= wdata_q[CTRL_TOGGLE_EN_BIT];
            ready_irq_enable_q  <= wdata_q[CTRL_READY_EN_BIT];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         upper_count_bound_q <= HIGH_RESET; // see RQ11
         lower_count_bound_q <= LOW_RESET; // see RQ12
      end else if (wr_fire && hit(awaddr_q, HIGH_OFFSET)) begin
         upper_count_bound_q <= merge16(upper_count_bound_q, wdata_q, wstrb_q);
      end else if (wr_fire && hit(awaddr_q, LOW_OFFSET)) begin
         lower_count_bound_q <= merge16(lower_count_bound_q, wdata_q, wstrb_q);
      end
   end

   // ----------------------------------------------------------------
   // Speed-sense input and counter
   // ----------------------------------------------------------------
   // The first sample after reset only primes the history, so a level
   // already present at start-up is not mistaken for a transition.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tach_q   <= 1'b0;
         primed_q <= 1'b0;
      end else begin
         tach_q   <= tach_in; // see RQ6
         primed_q <= 1'b1;
      end
   end

   assign tach_change = primed_q && (tach_in != tach_q); // see RQ4
   assign tach_rise   = tach_change && tach_in;

   speed_edge_counter #(
      .W   (CNT_W),
      .DIV (REF_DIV_CYCLES)
   ) u_counter (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .mode_select   (mode_select_q),
      .edge_select   (edge_select_q),
      .tach_rise     (tach_rise),
      .tach_change   (tach_change),
      .count_value   (edge_count_value),
      .count_latched (count_latched)
   );

   assign out_of_range = (edge_count_value > upper_count_bound_q) // see RQ11
                         || (edge_count_value < lower_count_bound_q); // see RQ7

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   assign clr_range  = wr_fire && hit(awaddr_q, STATUS_OFFSET) && wstrb_q[0]
                       && wdata_q[STAT_RANGE_BIT];
   assign clr_toggle = wr_fire && hit(awaddr_q, STATUS_OFFSET) && wstrb_q[0]
                       && wdata_q[STAT_TOGGLE_BIT];
   assign clr_ready  = wr_fire && hit(awaddr_q, STATUS_OFFSET) && wstrb_q[0]
                       && wdata_q[STAT_READY_BIT];

   // A new event in the clearing cycle wins, so no event is lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         range_violation_flag_q <= 1'b0;
      end else if (out_of_range) begin
         range_violation_flag_q <= 1'b1; // see RQ7
      end else if (clr_range) begin
         range_violation_flag_q <= 1'b0; // see RQ8
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         toggle_flag_q <= 1'b0;
      end else if (tach_change) begin
         toggle_flag_q <= 1'b1; // see RQ4
      end else if (clr_toggle) begin
         toggle_flag_q <= 1'b0; // see RQ5
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !mode_select_q) begin
         ready_flag_q <= 1'b0; // see RQ2
      end else if (count_latched) begin
         ready_flag_q <= 1'b1; // see RQ1
      end else if (clr_ready) begin
         ready_flag_q <= 1'b0; // see RQ3
      end
   end

   assign monitor_irq = (range_violation_flag_q && range_irq_enable_q) // see RQ8
                        || (toggle_flag_q && toggle_irq_enable_q) // see RQ5
                        || (ready_flag_q && ready_irq_enable_q); // see RQ14

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   assign status_word = {28'h0000000, ready_flag_q, toggle_flag_q, tach_q,
                         range_violation_flag_q}; // see RQ6
   assign ctrl_word   = {edge_count_value, ready_irq_enable_q, toggle_irq_enable_q, 1'b0,
                         edge_select_q, mode_select_q, 9'h000, range_irq_enable_q};
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         if (hit(s_axi_araddr, CTRL_OFFSET)) begin
            s_axi_rdata <= ctrl_word;
         end else if (hit(s_axi_araddr, STATUS_OFFSET)) begin
            s_axi_rdata <= status_word;
         end else if (hit(s_axi_araddr, HIGH_OFFSET)) begin
            s_axi_rdata <= {16'h0000, upper_count_bound_q};
         end else if (hit(s_axi_araddr, LOW_OFFSET)) begin
            s_axi_rdata <= {16'h0000, lower_count_bound_q};
         end else begin
            s_axi_rdata <= 32'h00000000;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic stat_rd;
   assign stat_rd = s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, STATUS_OFFSET);

   a_ready_on_latch: assert property ( // see RQ1
      mode_select_q && count_latched |=> ready_flag_q)
      else $error("ready flag missed a latch");
   a_ready_mode_zero: assert property ( // see RQ2
      !$past(mode_select_q) |-> !ready_flag_q)
      else $error("ready flag set in edge-count mode");
   a_ready_w1c: assert property ( // see RQ3
      clr_ready && !count_latched |=> !ready_flag_q ##0 !(ready_irq_enable_q
      && !range_violation_flag_q && !toggle_flag_q && monitor_irq))
      else $error("ready flag not cleared");
   a_toggle_set: assert property ( // see RQ4
      tach_change |=> toggle_flag_q)
      else $error("toggle flag missed a change");
   a_toggle_w1c: assert property ( // see RQ5
      clr_toggle && !tach_change |=> !toggle_flag_q)
      else $error("toggle flag not cleared");
   a_pin_level: assert property ( // see RQ6
      stat_rd |=> s_axi_rdata[STAT_PIN_BIT] == $past(tach_in, 2))
      else $error("pin bit does not follow the input");
   a_range_set: assert property ( // see RQ7
      (edge_count_value > upper_count_bound_q || edge_count_value < lower_count_bound_q)
      |=> range_violation_flag_q)
      else $error("range flag missed a trip");
   a_range_w1c: assert property ( // see RQ8
      clr_range && !out_of_range |=> !range_violation_flag_q)
      else $error("range flag not cleared");
   a_high_strict: assert property ( // see RQ11
      edge_count_value == upper_count_bound_q
      && edge_count_value >= lower_count_bound_q |-> !out_of_range)
      else $error("high trip not strict");
   a_low_zero: assert property ( // see RQ12
      lower_count_bound_q == 16'h0000
      && edge_count_value <= upper_count_bound_q |-> !out_of_range)
      else $error("zero low limit tripped");
   a_latch_mode: assert property ( // see RQ13
      count_latched |-> $past(mode_select_q))
      else $error("latch outside interval mode");
   a_irq_cause: assert property ( // see RQ14
      $rose(monitor_irq) |-> $past(count_latched) || $past(tach_change) || $past(out_of_range)
      || $changed(ctrl_word[15:0]) || $changed(range_irq_enable_q))
      else $error("interrupt rose without a cause");

   c_latch_irq: cover property (count_latched ##1 monitor_irq);
   c_toggle_clear: cover property (toggle_flag_q ##1 clr_toggle ##1 !toggle_flag_q);
   c_range_trip: cover property (out_of_range && range_irq_enable_q);

endmodule

`default_nettype wire

// File: src/speed_edge_counter.sv
`timescale 1ns/1ps
`default_nettype none

module speed_edge_counter
   import fan_speed_pkg::*;
#(
   parameter int W   = CNT_W,
   parameter int DIV = REF_DIV_CYCLES
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         mode_select,
   input  wire logic [1:0]   edge_select,
   input  wire logic         tach_rise,
   input  wire logic         tach_change,
   output logic      [W-1:0] count_value,
   output logic              count_latched
);

   // ----------------------------------------------------------------
   // Reference tick divider
   // ----------------------------------------------------------------
   logic [11:0]  div_q;
   logic         ref_tick;
   logic [W-1:0] cnt_q;
   logic [3:0]   edges_q;
   logic         armed_q;
   logic         close_now;

   assign ref_tick = (div_q == 12'(DIV - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn || ref_tick) begin
         div_q <= 12'h000;
      end else begin
         div_q <= div_q + 12'h001;
      end
   end

   // ----------------------------------------------------------------
   // Interval measurement
   // ----------------------------------------------------------------
   // The interval is opened by the first edge, so it does not start mid-period.
   assign close_now = mode_select && armed_q && tach_change
                      && (edges_q + 4'h1 == edges_needed(edge_select));

   always_ff @(posedge aclk) begin
      if (!aresetn || !mode_select) begin
         armed_q <= 1'b0;
         edges_q <= 4'h0;
      end else if (tach_change) begin
         armed_q <= 1'b1;
         edges_q <= close_now ? 4'h1 : edges_q + 4'h1;
      end
   end

   // Saturates instead of wrapping, so an interval longer than the count range latches as slowest.
   always_ff @(posedge aclk) begin
      if (!aresetn || !mode_select || close_now || !armed_q) begin
         cnt_q <= '0;
      end else if (ref_tick && cnt_q != '1) begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_value <= '0;
      end else if (close_now) begin
         count_value <= cnt_q; // see RQ13
      end else if (!mode_select && tach_rise && count_value != '1) begin
         count_value <= count_value + W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_latched <= 1'b0;
      end else begin
         count_latched <= close_now; // see RQ13
      end
   end

endmodule

`default_nettype wire

// File: testbench/tach_model.sv
`timescale 1ns/1ps
`default_nettype none

module tach_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        run,
   input  wire logic [15:0] half,
   input  wire logic        init_level,
   output logic             tach_in,
   output logic [15:0]      rise_count
);
   logic [15:0] cnt_q;

   // ----------------------------------------------------------------
   // Speed-sense output
   // ----------------------------------------------------------------
   // A stalled rotor holds its level, so the monitor sees no edge at all.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tach_in    <= init_level;
         cnt_q      <= 16'h0000;
         rise_count <= 16'h0000;
      end else if (!run) begin
         cnt_q <= 16'h0000;
      end else if (cnt_q == half - 16'h0001) begin
         cnt_q   <= 16'h0000;
         tach_in <= !tach_in;
         if (!tach_in) begin
            rise_count <= rise_count + 16'h0001;
         end
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule

`default_nettype wire

// File: testbench/tb_fan_speed_monitor_status.sv
`timescale 1ns/1ps
`default_nettype none

module tb_fan_speed_monitor_status;
   import fan_speed_pkg::*;

   logic              aclk;
   logic              aresetn;
   logic [ADDR_W-1:0] awaddr;
   logic              awvalid;
   logic              awready;
   logic [31:0]       wdata;
   logic              wvalid;
   logic [3:0]        wstrb;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready;
   logic [ADDR_W-1:0] araddr;
   logic              arvalid;
   logic              arready;
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready;
   logic              tach_in;
   logic              monitor_irq;
   logic              run;
   logic [15:0]       half;
   logic [15:0]       rise_count;
   int                n_mismatch;
   int                num_checks;
   logic [31:0]       rd;
   logic [1:0]        rsp;

   fan_speed_monitor_status DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .tach_in(tach_in), .monitor_irq(monitor_irq));

   tach_model fan (
      .aclk(aclk), .aresetn(aresetn), .run(run), .half(half),
      .init_level(1'b1), .tach_in(tach_in), .rise_count(rise_count));

   // ----------------------------------------------------------------
   // Clock, reset and closing
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #4 aclk = !aclk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic timed_out();
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
      wrap_up();
   endtask

   // ----------------------------------------------------------------
   // Bus master
   // ----------------------------------------------------------------
   // Handshakes are judged right after the rising edge, before its updates land,
   // so each channel is released exactly at the edge that took it.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            rsp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (i == 100) timed_out();
   endtask

   task automatic axi_read(input logic [7:0] a);
      int i;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rd  = rdata;
            rsp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (i == 100) timed_out();
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset();
      axi_read(STATUS_OFFSET);
      check(rd, 32'h0000_0002);
      check(32'(rsp), 32'(RESP_OKAY));
      axi_read(HIGH_OFFSET);
      check(rd, 32'h0000_FFFF);
      axi_read(LOW_OFFSET);
      check(rd, 32'h0000_0000);
      axi_read(8'h10);
      check(rd, 32'h0);
      check(32'(rsp), 32'(RESP_SLVERR));
      axi_write(8'h10, 32'h0000_0001);
      check(32'(rsp), 32'(RESP_SLVERR));
      axi_write(STATUS_OFFSET, 32'hFFFF_FFFF);
      check(32'(rsp), 32'(RESP_OKAY));
      axi_read(STATUS_OFFSET);
      check(rd, 32'h0000_0002);
      check({31'h0, monitor_irq}, 32'h0);
      $display("test reset done");
   endtask

   task automatic test_toggle();
      axi_write(CTRL_OFFSET, 32'h0000_4000);
      half <= 16'h0004;
      run  <= 1'b1;
      repeat (21) @(posedge aclk);
      run <= 1'b0;
      repeat (4) @(posedge aclk);
      axi_read(STATUS_OFFSET);
      check(32'(rd[3:1]), 32'({2'b01, tach_in}));
      check({31'h0, monitor_irq}, 32'h1);
      axi_write(STATUS_OFFSET, 32'h0000_0004);
      axi_read(STATUS_OFFSET);
      check(32'(rd[2]), 32'h0);
      check({31'h0, monitor_irq}, 32'h0);
      axi_read(CTRL_OFFSET);
      check(32'(rd[31:16]), 32'(rise_count));
      $display("test toggle done");
   endtask

   task automatic test_range();
      axi_write(CTRL_OFFSET, 32'h0000_0001);
      axi_write(HIGH_OFFSET, {16'h0, rise_count - 16'h0001});
      axi_read(STATUS_OFFSET);
      check(32'(rd[0]), 32'h1);
      check({31'h0, monitor_irq}, 32'h1);
      axi_write(HIGH_OFFSET, {16'h0, rise_count});
      wstrb <= 4'hE;
      axi_write(STATUS_OFFSET, 32'h0000_0001);
      axi_read(STATUS_OFFSET);
      check(32'(rd[0]), 32'h1);
      wstrb <= 4'hF;
      axi_write(STATUS_OFFSET, 32'h0000_0001);
      axi_read(STATUS_OFFSET);
      check(32'(rd[0]), 32'h0);
      check({31'h0, monitor_irq}, 32'h0);
      axi_write(HIGH_OFFSET, 32'h0000_FFFF);
      $display("test range done");
   endtask

   task automatic test_interval();
      int i;
      axi_write(LOW_OFFSET, 32'h0000_0100);
      axi_write(CTRL_OFFSET, 32'h0000_8400);
      half <= 16'd2500;
      run  <= 1'b1;
      rd = 32'h0;
      for (i = 0; i < 60 && !rd[3]; i++) begin
         repeat (500) @(posedge aclk);
         axi_read(STATUS_OFFSET);
      end
      if (i == 60) timed_out();
      run <= 1'b0;
      check(32'({rd[3], rd[0]}), 32'h3);
      check({31'h0, monitor_irq}, 32'h1);
      axi_read(CTRL_OFFSET);
      check(32'(rd[31:16] >= 16'h0001 && rd[31:16] <= 16'h0003), 32'h1);
      axi_write(LOW_OFFSET, 32'h0000_0000);
      axi_write(STATUS_OFFSET, 32'h0000_0009);
      axi_read(STATUS_OFFSET);
      check(32'({rd[3], rd[0]}), 32'h0);
      check({31'h0, monitor_irq}, 32'h0);
      axi_write(CTRL_OFFSET, 32'h0000_0000);
      axi_read(STATUS_OFFSET);
      check(32'(rd[3]), 32'h0);
      $display("test interval done");
   endtask

   initial begin
      n_mismatch = 0;
      num_checks = 0;
      aresetn    = 1'b0;
      awaddr     = 8'h00;
      awvalid    = 1'b0;
      wdata      = 32'h0;
      wvalid     = 1'b0;
      wstrb      = 4'hF;
      bready     = 1'b0;
      araddr     = 8'h00;
      arvalid    = 1'b0;
      rready     = 1'b0;
      run        = 1'b0;
      half       = 16'h0004;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      test_reset();
      test_toggle();
      test_range();
      test_interval();
      wrap_up();
   end
endmodule

`default_nettype wire
